//--- shared/vic_defs.vh
// Constants shared by the vectored interrupt controller
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH

// ----------------------------------------------------------------
// Source counts, shared line, field widths and idle level
// ----------------------------------------------------------------
`define VIC_NUM_LINES      25
`define VIC_NUM_PRIO       24
`define VIC_SHARED_LINE    24
`define VIC_SHARED_PRIO    5'h0e
`define VIC_LEVEL_W        2
`define VIC_BANK_W         3
`define VIC_LEVEL_NONE     3'h4

// ----------------------------------------------------------------
// Fixed vector table entries and macro service control word base
// ----------------------------------------------------------------
`define VIC_VEC_RESET      16'h0000
`define VIC_VEC_NMI        16'h0002
`define VIC_VEC_TRAP       16'h003c
`define VIC_VEC_BRK        16'h003e
`define VIC_MS_BASE        16'hfe00

// ----------------------------------------------------------------
// Maskable vector table entries by default priority
// ----------------------------------------------------------------
`define VIC_VEC_P0         16'h0006
`define VIC_VEC_P1         16'h0008
`define VIC_VEC_P2         16'h000a
`define VIC_VEC_P3         16'h000c
`define VIC_VEC_P4         16'h000e
`define VIC_VEC_P5         16'h0010
`define VIC_VEC_P6         16'h0012
`define VIC_VEC_P7         16'h0014
`define VIC_VEC_P8         16'h0016
`define VIC_VEC_P9         16'h0018
`define VIC_VEC_P10        16'h001a
`define VIC_VEC_P11        16'h001c
`define VIC_VEC_P12        16'h0020
`define VIC_VEC_P13        16'h0022
`define VIC_VEC_P14        16'h0024
`define VIC_VEC_P15        16'h0026
`define VIC_VEC_P16        16'h0028
`define VIC_VEC_P17        16'h002a
`define VIC_VEC_P18        16'h002c
`define VIC_VEC_P19        16'h002e
`define VIC_VEC_P20        16'h0030
`define VIC_VEC_P21        16'h0034
`define VIC_VEC_P22        16'h0036
`define VIC_VEC_P23        16'h003a

// ----------------------------------------------------------------
// Stack frame offsets below the stack pointer
// ----------------------------------------------------------------
`define VIC_SP_PSW_OFS     16'h0002
`define VIC_SP_PC_OFS      16'h0004

`endif

//--- hdl/vic_req_flag.v
// Sticky request flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none

module vic_req_flag (
  input  wire i_clk_sys,
  input  wire i_reset_n,
  input  wire i_set,
  input  wire i_clr,
  output wire o_flag
);

  reg flag_r;

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flag_r <= 1'b0;
    end else if (i_set) begin
      flag_r <= 1'b1;
    end else if (i_clr) begin
      flag_r <= 1'b0;
    end
  end

  assign o_flag = flag_r;

endmodule

`default_nettype wire

//--- hdl/vic_prio_arb.v
// Level and default priority arbiter for maskable lines
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.vh"

module vic_prio_arb #(
  parameter N  = 25,
  parameter LW = 2
) (
  input  wire [N-1:0]    i_pend,
  input  wire [N*LW-1:0] i_level,
  input  wire [LW:0]     i_cur_level,
  output reg             o_found,
  output reg  [4:0]      o_idx
);

  integer         i;
  reg [LW+4:0]    key;
  reg [LW+4:0]    best_key;
  reg [4:0]       dprio;

  // ----------------------------------------------------------------
  // Lowest key wins: level first, then default priority
  // ----------------------------------------------------------------
  always @* begin
    o_found  = 1'b0;
    o_idx    = 5'h00;
    best_key = {(LW+5){1'b1}};
    key      = {(LW+5){1'b0}};
    dprio    = 5'h00;
    for (i = 0; i < N; i = i + 1) begin
      dprio = (i == `VIC_SHARED_LINE) ? `VIC_SHARED_PRIO : i[4:0];
      key   = {i_level[i*LW +: LW], dprio};
      if (i_pend[i] && ({1'b0, i_level[i*LW +: LW]} < i_cur_level) &&
          (!o_found || key < best_key)) begin
        o_found  = 1'b1;
        o_idx    = i[4:0];
        best_key = key;
      end
    end
  end

endmodule

`default_nettype wire

//--- hdl/vic_core.v
// Vectored interrupt controller: request capture, arbitration, entry sequencing
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.vh"

module vic_core #(
  parameter NL = `VIC_NUM_LINES,
  parameter LW = `VIC_LEVEL_W,
  parameter BW = `VIC_BANK_W
) (
  input  wire            i_clk_sys,
  input  wire            i_reset_n,
  input  wire [NL-1:0]   i_irq_req,
  input  wire [NL-1:0]   i_irq_clear,
  input  wire [NL-1:0]   i_irq_mask,
  input  wire [NL*LW-1:0] i_irq_level,
  input  wire [NL-1:0]   i_irq_ctx_sw,
  input  wire [NL-1:0]   i_irq_macro,
  input  wire [NL*BW-1:0] i_irq_bank,
  input  wire            i_nmi_edge,
  input  wire            i_operand_error,
  input  wire            i_software_break,
  input  wire            i_bank_switch_break,
  input  wire [BW-1:0]   i_break_bank,
  input  wire            i_int_enable,
  input  wire [LW:0]     i_cur_level,
  input  wire            i_boundary,
  input  wire [15:0]     i_program_counter,
  input  wire [15:0]     i_program_status_word,
  input  wire [15:0]     i_sp,
  input  wire [15:0]     i_bank_vector,
  input  wire            i_mem_ack,
  input  wire [15:0]     i_mem_rdata,
  input  wire            i_ms_done,
  input  wire            i_ms_count_zero,
  output wire            o_mem_req,
  output wire            o_mem_we,
  output wire [15:0]     o_mem_addr,
  output wire [15:0]     o_mem_wdata,
  output wire            o_ms_req,
  output wire [15:0]     o_ms_word_addr,
  output wire            o_bank_save,
  output wire [BW-1:0]   o_bank_sel,
  output wire [15:0]     o_bank_save_pc,
  output wire [15:0]     o_bank_save_psw,
  output wire            o_pc_load,
  output wire [15:0]     o_pc_value,
  output wire            o_sp_load,
  output wire [15:0]     o_sp_value,
  output wire [4:0]      o_ack_src,
  output wire [LW:0]     o_ack_level,
  output wire            o_busy
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_PUSH_PSW = 3'h1;
  localparam [2:0] ST_PUSH_PC  = 3'h2;
  localparam [2:0] ST_FETCH    = 3'h3;
  localparam [2:0] ST_CS_SAVE  = 3'h4;
  localparam [2:0] ST_LOAD     = 3'h5;
  localparam [2:0] ST_MS_WAIT  = 3'h6;

  localparam NF = NL + 4;

  reg [2:0]    state_r;
  reg [2:0]    state_nxt;
  reg [15:0]   vec_r;
  reg [15:0]   pc_r;
  reg [15:0]   sp_r;
  reg [15:0]   psw_r;
  reg [15:0]   pcsave_r;
  reg [15:0]   ms_addr_r;
  reg [BW-1:0] bank_r;
  reg [4:0]    src_r;
  reg [LW:0]   lvl_r;
  reg          push_r;

  wire [NF-1:0] flag;
  reg  [NF-1:0] take_clr;
  wire          found;
  wire [4:0]    win;

  // ----------------------------------------------------------------
  // Request flags: maskable lines, then nmi, trap, break, bank break
  // ----------------------------------------------------------------
  wire [NF-1:0] set_vec = {i_bank_switch_break, i_software_break, i_operand_error,
                           i_nmi_edge, i_irq_req};
  wire [NF-1:0] clr_vec = {4'h0, i_irq_clear} | take_clr;

  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_flag
      vic_req_flag u_flag (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_set     (set_vec[g]),
        .i_clr     (clr_vec[g]),
        .o_flag    (flag[g])
      );
    end
  endgenerate

  wire f_nmi   = flag[NL];
  wire f_trap  = flag[NL+1];
  wire f_brk   = flag[NL+2];
  wire f_bank_switch_break = flag[NL+3];

  // ----------------------------------------------------------------
  // Arbitration of unmasked maskable lines
  // ----------------------------------------------------------------
  vic_prio_arb #(
    .N  (NL),
    .LW (LW)
  ) u_arb (
    .i_pend      (flag[NL-1:0] & ~i_irq_mask & {NL{i_int_enable}}),
    .i_level     (i_irq_level),
    .i_cur_level (i_cur_level),
    .o_found     (found),
    .o_idx       (win)
  );

  // ----------------------------------------------------------------
  // Default priority to vector table entry
  // ----------------------------------------------------------------
  function [15:0] vec_of;
    input [4:0] idx;
    begin
      case (idx)
        5'd0:  vec_of = `VIC_VEC_P0;
        5'd1:  vec_of = `VIC_VEC_P1;
        5'd2:  vec_of = `VIC_VEC_P2;
        5'd3:  vec_of = `VIC_VEC_P3;
        5'd4:  vec_of = `VIC_VEC_P4;
        5'd5:  vec_of = `VIC_VEC_P5;
        5'd6:  vec_of = `VIC_VEC_P6;
        5'd7:  vec_of = `VIC_VEC_P7;
        5'd8:  vec_of = `VIC_VEC_P8;
        5'd9:  vec_of = `VIC_VEC_P9;
        5'd10: vec_of = `VIC_VEC_P10;
        5'd11: vec_of = `VIC_VEC_P11;
        5'd12: vec_of = `VIC_VEC_P12;
        5'd13: vec_of = `VIC_VEC_P13;
        5'd14: vec_of = `VIC_VEC_P14;
        5'd15: vec_of = `VIC_VEC_P15;
        5'd16: vec_of = `VIC_VEC_P16;
        5'd17: vec_of = `VIC_VEC_P17;
        5'd18: vec_of = `VIC_VEC_P18;
        5'd19: vec_of = `VIC_VEC_P19;
        5'd20: vec_of = `VIC_VEC_P20;
        5'd21: vec_of = `VIC_VEC_P21;
        5'd22: vec_of = `VIC_VEC_P22;
        5'd23: vec_of = `VIC_VEC_P23;
        5'd24: vec_of = `VIC_VEC_P14;
        default: vec_of = `VIC_VEC_P23;
      endcase
    end
  endfunction

  wire [15:0] win_vec = vec_of(win);
  wire        win_ms  = i_irq_macro[win];
  wire        win_cs  = i_irq_ctx_sw[win];

  // ----------------------------------------------------------------
  // Acceptance and next state
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    take_clr  = {NF{1'b0}};
    case (state_r)
      ST_IDLE: begin
        if (i_boundary) begin
          if (f_trap) begin
            take_clr[NL+1] = 1'b1;
            state_nxt      = ST_PUSH_PSW;
          end else if (f_brk) begin
            take_clr[NL+2] = 1'b1;
            state_nxt      = ST_PUSH_PSW;
          end else if (f_bank_switch_break) begin
            take_clr[NL+3] = 1'b1;
            state_nxt      = ST_CS_SAVE;
          end else if (f_nmi) begin
            take_clr[NL]   = 1'b1;
            state_nxt      = ST_PUSH_PSW;
          end else if (found) begin
            take_clr[win]  = 1'b1;
            if (win_ms) begin
              state_nxt = ST_MS_WAIT;
            end else if (win_cs) begin
              state_nxt = ST_CS_SAVE;
            end else begin
              state_nxt = ST_PUSH_PSW;
            end
          end
        end
      end
      ST_MS_WAIT: begin
        if (i_ms_done) begin
          state_nxt = i_ms_count_zero ? ST_PUSH_PSW : ST_IDLE;
        end
      end
      ST_PUSH_PSW: begin
        if (i_mem_ack) begin
          state_nxt = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (i_mem_ack) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (i_mem_ack) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_CS_SAVE: begin
        state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r   <= ST_FETCH;
      vec_r     <= `VIC_VEC_RESET;
      pc_r      <= 16'h0000;
      sp_r      <= 16'h0000;
      psw_r     <= 16'h0000;
      pcsave_r  <= 16'h0000;
      ms_addr_r <= 16'h0000;
      bank_r    <= {BW{1'b0}};
      src_r     <= 5'h1f;
      lvl_r     <= `VIC_LEVEL_NONE;
      push_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && state_nxt != ST_IDLE) begin
        sp_r     <= i_sp;
        psw_r    <= i_program_status_word;
        pcsave_r <= i_program_counter;
        push_r   <= (state_nxt != ST_CS_SAVE);
        if (f_trap) begin
          vec_r <= `VIC_VEC_TRAP;
        end else if (f_brk) begin
          vec_r <= `VIC_VEC_BRK;
        end else if (f_bank_switch_break) begin
          bank_r <= i_break_bank;
        end else if (f_nmi) begin
          vec_r <= `VIC_VEC_NMI;
        end else begin
          vec_r     <= win_vec;
          ms_addr_r <= `VIC_MS_BASE | win_vec;
          bank_r    <= i_irq_bank[win*BW +: BW];
          src_r     <= win;
          lvl_r     <= {1'b0, i_irq_level[win*LW +: LW]};
        end
      end
      if (state_r == ST_FETCH && i_mem_ack) begin
        pc_r <= i_mem_rdata;
      end
      if (state_r == ST_CS_SAVE) begin
        pc_r <= i_bank_vector;
      end
      if (state_r == ST_LOAD) begin
        push_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_mem_req   = (state_r == ST_PUSH_PSW) || (state_r == ST_PUSH_PC) || (state_r == ST_FETCH);
  assign o_mem_we    = (state_r == ST_PUSH_PSW) || (state_r == ST_PUSH_PC);
  assign o_mem_addr  = (state_r == ST_PUSH_PSW) ? (sp_r - `VIC_SP_PSW_OFS) :
                       (state_r == ST_PUSH_PC)  ? (sp_r - `VIC_SP_PC_OFS)  : vec_r;
  assign o_mem_wdata = (state_r == ST_PUSH_PSW) ? psw_r : pcsave_r;

  assign o_ms_req       = (state_r == ST_MS_WAIT);
  assign o_ms_word_addr = ms_addr_r;

  assign o_bank_save     = (state_r == ST_CS_SAVE);
  assign o_bank_sel      = bank_r;
  assign o_bank_save_pc  = pcsave_r;
  assign o_bank_save_psw = psw_r;

  assign o_pc_load  = (state_r == ST_LOAD);
  assign o_pc_value = pc_r;
  assign o_sp_load  = (state_r == ST_LOAD) && push_r && (vec_r != `VIC_VEC_RESET || src_r != 5'h1f);
  assign o_sp_value = sp_r - `VIC_SP_PC_OFS;

  assign o_ack_src   = src_r;
  assign o_ack_level = lvl_r;
  assign o_busy      = (state_r != ST_IDLE);

endmodule

`default_nettype wire

//--- sim/vic_mem_model.sv
// Memory and macro service partner for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_slow,
  input  wire logic        i_mem_req,
  input  wire logic [15:0] i_mem_addr,
  input  wire logic        i_ms_req,
  output var  logic        o_mem_ack,
  output var  logic [15:0] o_mem_rdata,
  output var  logic        o_ms_done
);
  logic [1:0] wait_r;
  logic       go;
  assign go = i_reset_n && (i_mem_req || i_ms_req) && !o_mem_ack && !o_ms_done;
  // ----------------------------------------------------------------
  // Answer after zero or two idle cycles
  // ----------------------------------------------------------------
  always @(negedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_mem_ack <= 1'b0;
      o_ms_done <= 1'b0;
      o_mem_rdata <= 16'h0;
      wait_r <= 2'h0;
    end else if (go && wait_r >= {i_slow, 1'b0}) begin
      o_mem_ack <= i_mem_req;
      o_ms_done <= i_ms_req;
      o_mem_rdata <= 16'h8000 | i_mem_addr;
      wait_r <= 2'h0;
    end else begin
      o_mem_ack <= 1'b0;
      o_ms_done <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      wait_r <= go ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

//--- sim/vic_core_checker.sv
// Assertion checker for the interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module vic_core_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  input wire logic [15:0] i_program_counter,
  input wire logic [15:0] i_program_status_word,
  input wire logic [15:0] i_sp,
  input wire logic [15:0] i_bank_vector,
  input wire logic        i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  input wire logic        o_mem_req,
  input wire logic        o_mem_we,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic        o_ms_req,
  input wire logic [15:0] o_ms_word_addr,
  input wire logic        o_bank_save,
  input wire logic [15:0] o_bank_save_pc,
  input wire logic [15:0] o_bank_save_psw,
  input wire logic        o_pc_load,
  input wire logic [15:0] o_pc_value,
  input wire logic        o_sp_load,
  input wire logic [15:0] o_sp_value,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  sequence s_read_done;
    o_mem_req && !o_mem_we && i_mem_ack;
  endsequence
  sequence s_ctx_save;
    o_bank_save && !o_mem_req;
  endsequence
  a_read_loads_pc: assert property (s_read_done |=> o_pc_load && o_pc_value == $past(i_mem_rdata))
    else $error("pc not loaded from table");
  a_psw_push_data: assert property (o_mem_req && o_mem_we && o_mem_addr == i_sp - 16'h0002 |-> o_mem_wdata == i_program_status_word)
    else $error("status word push wrong");
  a_pc_push_data: assert property (o_mem_req && o_mem_we && o_mem_addr == i_sp - 16'h0004 |-> o_mem_wdata == i_program_counter)
    else $error("counter push wrong");
  a_sp_with_pc: assert property (o_sp_load |-> o_pc_load && o_sp_value == i_sp - 16'h0004)
    else $error("stack pointer load wrong");
  a_bank_branch: assert property (s_ctx_save |=> o_pc_load && !o_sp_load && o_pc_value == $past(i_bank_vector))
    else $error("bank branch wrong");
  a_bank_saves_ctx: assert property (o_bank_save |-> o_bank_save_pc == i_program_counter && o_bank_save_psw == i_program_status_word)
    else $error("bank save values wrong");
  a_save_one_pulse: assert property (o_bank_save |=> !o_bank_save)
    else $error("bank save too long");
  a_idle_after_load: assert property (o_pc_load |=> !o_busy && !o_pc_load)
    else $error("not idle after load");
  a_ms_word_range: assert property (o_ms_req |-> o_ms_word_addr[15:8] == 8'hfe && !o_mem_req && !o_pc_load)
    else $error("control word address wrong");
  a_vec_read_addr: assert property (o_mem_req && !o_mem_we |-> !o_mem_addr[0] && o_mem_addr <= 16'h003e)
    else $error("vector read out of table");
endmodule
bind vic_core vic_core_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_program_counter(i_program_counter),
  .i_program_status_word(i_program_status_word), .i_sp(i_sp), .i_bank_vector(i_bank_vector),
  .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
  .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_ms_req(o_ms_req), .o_ms_word_addr(o_ms_word_addr),
  .o_bank_save(o_bank_save), .o_bank_save_pc(o_bank_save_pc), .o_bank_save_psw(o_bank_save_psw),
  .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_sp_load(o_sp_load), .o_sp_value(o_sp_value),
  .o_busy(o_busy));
`default_nettype wire

//--- sim/vic_core_test.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_core_test;
  logic        clk = 1'b0, rst_n = 1'b0, nmi = 1'b0, oper = 1'b0, software_break = 1'b0, bbrk = 1'b0;
  logic        bound = 1'b1, slow = 1'b0, cz = 1'b0, ack, ms_done, mreq, mwe, msr, bsv, pcl, spl, busy;
  logic        ien = 1'b1, push_exp = 1'b0;
  logic [24:0] req = '0, mask = '0, ctx = '0, macro = '0, clr = '0;
  logic [49:0] lvl = '0;
  logic [74:0] bank = '0;
  logic [2:0]  bbank = 3'h0, xbank = 3'h0, bsel, alev, cur = 3'h4, last_lv = 3'h4;
  logic [15:0] pc = '0, program_status_word = '0, sp = 16'h0400, bvec = '0, rdata, addr, wdata, msw, bpc, bpsw, pcv, spv;
  logic [4:0]  asrc, last = 5'h1f;
  logic [24:0] q[$], e;
  logic [31:0] lf = 32'he70f;
  logic [15:0] vec [25] = '{16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0012,
    16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h0020, 16'h0022, 16'h0024, 16'h0026,
    16'h0028, 16'h002a, 16'h002c, 16'h002e, 16'h0030, 16'h0034, 16'h0036, 16'h003a, 16'h0024};
  int          n_errors = 0, cmp_count = 0, cyc = 0;
  always #25 clk = ~clk;
  vic_mem_model u_mem (.i_clk_sys(clk), .i_reset_n(rst_n), .i_slow(slow), .i_mem_req(mreq),
    .i_mem_addr(addr), .i_ms_req(msr), .o_mem_ack(ack), .o_mem_rdata(rdata), .o_ms_done(ms_done));
  vic_core uut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_irq_req(req), .i_irq_clear(clr),
    .i_irq_mask(mask), .i_irq_level(lvl), .i_irq_ctx_sw(ctx), .i_irq_macro(macro), .i_irq_bank(bank),
    .i_nmi_edge(nmi), .i_operand_error(oper), .i_software_break(software_break), .i_bank_switch_break(bbrk),
    .i_break_bank(bbank), .i_int_enable(ien), .i_cur_level(cur), .i_boundary(bound),
    .i_program_counter(pc), .i_program_status_word(program_status_word), .i_sp(sp), .i_bank_vector(bvec),
    .i_mem_ack(ack), .i_mem_rdata(rdata), .i_ms_done(ms_done), .i_ms_count_zero(cz),
    .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(addr), .o_mem_wdata(wdata), .o_ms_req(msr),
    .o_ms_word_addr(msw), .o_bank_save(bsv), .o_bank_sel(bsel), .o_bank_save_pc(bpc),
    .o_bank_save_psw(bpsw), .o_pc_load(pcl), .o_pc_value(pcv), .o_sp_load(spl), .o_sp_value(spv),
    .o_ack_src(asrc), .o_ack_level(alev), .o_busy(busy));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic expect_pc(input logic [15:0] v);
    q.push_back({push_exp, last_lv, last, v});
  endtask
  task automatic fire(input logic [24:0] m, input logic [3:0] s);
    lf = lfsr_next(lf);
    pc = lf[15:0];
    program_status_word = lf[31:16];
    sp = {lf[23:9], 1'b0};
    bvec = lf[27:12];
    slow = lf[3];
    req = m;
    {nmi, oper, software_break, bbrk} = s;
    @(negedge clk);
    req = '0;
    {nmi, oper, software_break, bbrk} = 4'h0;
  endtask
  task automatic drain();
    int t;
    t = 0;
    repeat (3) @(negedge clk);
    while ((q.size() > 0 || busy !== 1'b0) && t < 500) begin
      @(negedge clk);
      t++;
    end
    if (t >= 500) check(16'h0, 16'hffff);
    @(negedge clk);
  endtask
  // ----------------------------------------------------------------
  // Output monitor and timeout
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (rst_n && pcl === 1'b1) begin
      if (q.size() == 0) check(16'h0, 16'hffff);
      else begin
        e = q.pop_front();
        check(pcv, e[15:0]);
        check({11'h0, asrc}, {11'h0, e[20:16]});
        check({13'h0, alev}, {13'h0, e[23:21]});
        check({15'h0, spl}, {15'h0, e[24]});
      end
    end
    if (rst_n && bsv === 1'b1) check({13'h0, bsel}, {13'h0, xbank});
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    expect_pc(16'h8000);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    drain();
    push_exp = 1'b1;
    last_lv = 3'h0;
    for (int n = 0; n < 25; n++) begin
      last = n[4:0];
      expect_pc(16'h8000 | vec[n]);
      fire(25'h1 << n, 4'h0);
      drain();
    end
    lvl[1:0] = 2'h2;
    lvl[43:42] = 2'h1;
    cur = 3'h2;
    last = 5'd21;
    last_lv = 3'h1;
    expect_pc(16'h8034);
    fire(25'h0200001, 4'h0);
    drain();
    last = 5'd0;
    last_lv = 3'h2;
    expect_pc(16'h8006);
    cur = 3'h4;
    drain();
    lvl = '0;
    last_lv = 3'h0;
    last = 5'd14;
    expect_pc(16'h8024);
    last = 5'd24;
    expect_pc(16'h8024);
    fire(25'h1004000, 4'h0);
    drain();
    mask[5] = 1'b1;
    mask[6] = 1'b1;
    fire(25'h60, 4'h0);
    clr[6] = 1'b1;
    @(negedge clk);
    clr = '0;
    drain();
    ien = 1'b0;
    mask = '0;
    repeat (10) @(negedge clk);
    bound = 1'b0;
    ien = 1'b1;
    repeat (10) @(negedge clk);
    last = 5'd5;
    expect_pc(16'h8010);
    bound = 1'b1;
    drain();
    expect_pc(16'h803c);
    expect_pc(16'h803e);
    expect_pc(16'h8002);
    fire('0, 4'he);
    drain();
    push_exp = 1'b0;
    ctx[3] = 1'b1;
    bank[11:9] = 3'h5;
    xbank = 3'h5;
    last = 5'd3;
    fire(25'h8, 4'h0);
    expect_pc(bvec);
    drain();
    bbank = 3'h2;
    xbank = 3'h2;
    fire('0, 4'h1);
    expect_pc(bvec);
    drain();
    macro[13] = 1'b1;
    ctx[13] = 1'b1;
    last = 5'd13;
    fire(25'h2000, 4'h0);
    for (int t = 0; t < 50 && msr !== 1'b1; t++) @(negedge clk);
    check(msw, 16'hfe22);
    drain();
    cz = 1'b1;
    push_exp = 1'b1;
    expect_pc(16'h8022);
    fire(25'h2000, 4'h0);
    drain();
    conclude();
  end
endmodule
`default_nettype wire
